/* leq_regs.sv */
`timescale 1ns/1ps

// Overview of operation
// - Error counting runs only while enable bit set.
// - Lock drops when error count reaches threshold.
// - Counting disabled: first link error drops lock.
// - Pixel-rate counter watches both clocks and data.
// - Mode 000 normal pins; 001-011 fast 1/2/4.
// - Modes 100-111: forward/reverse SPI, normal/fast.
// - Polarity bit chooses launch and sample edges.
// - Reverse SPI data-out tri-states when deselected only if gate bit 4 is set.
// - Bypass uses manual bits 7-5 as select 5-3.
// - Bypass uses manual bits 3-1 as select 2-0.
// - Adaptation starts from floor, reset eight.
// - Second-port access steers floor writes there.
// - Source bit picks first or second input.
// - Source field 01 first, 10 second.
// - Loop driver active only with enable bit.
// - Second-port access reaches port registers plus shared.
// - Floor applies only with floor-apply control set.
module leq_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire leq_pkg::leq_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic second_port_access_i,
  input wire logic floor_apply_i,
  input wire logic pix_en_i,
  input wire logic [2:0] link_err_i,
  input wire logic relock_i,
  output logic lock_o,
  input wire logic [5:0] eq_state_p0_i,
  input wire logic [5:0] eq_state_p1_i,
  output logic [5:0] eq_sel_p0_o,
  output logic [5:0] eq_sel_p1_o,
  output logic [3:0] eq_start_p0_o,
  output logic [3:0] eq_start_p1_o,
  output leq_pkg::leq_bc_cfg_t bc_cfg_o,
  output logic spi_launch_rise_o,
  output logic spi_sample_rise_o,
  input wire logic spi_ss_n_i,
  input wire logic spi_miso_data_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic first_link_data_i,
  input wire logic second_link_data_i,
  output logic loop_through_output_o,
  output logic loop_driver_on_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(leq_pkg::leq_reg_req_t req, logic [7:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  function automatic leq_pkg::leq_bc_cfg_t bc_decode(logic [2:0] mode);
    leq_pkg::leq_bc_cfg_t cfg;
    cfg = '0;
    case (mode)
      leq_pkg::BC_PIN_NORMAL: cfg.pins = 3'h0;
      leq_pkg::BC_PIN_FAST1:
      begin
        cfg.fast = 1'b1;
        cfg.pins = 3'h1;
      end
      leq_pkg::BC_PIN_FAST2:
      begin
        cfg.fast = 1'b1;
        cfg.pins = 3'h2;
      end
      leq_pkg::BC_PIN_FAST4:
      begin
        cfg.fast = 1'b1;
        cfg.pins = 3'h4;
      end
      leq_pkg::BC_SPI_FWD_NORMAL: cfg.spi = 1'b1;
      leq_pkg::BC_SPI_REV_NORMAL:
      begin
        cfg.spi = 1'b1;
        cfg.reverse = 1'b1;
      end
      leq_pkg::BC_SPI_FWD_FAST:
      begin
        cfg.spi = 1'b1;
        cfg.fast = 1'b1;
      end
      leq_pkg::BC_SPI_REV_FAST:
      begin
        cfg.spi = 1'b1;
        cfg.fast = 1'b1;
        cfg.reverse = 1'b1;
      end
      default: cfg = '0;
    endcase
    return cfg;
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] link_err_q;
  logic [7:0] back_chan_q;
  logic [7:0] eq_manual_q;
  logic [7:0] eq_floor_p0_q;
  logic [7:0] eq_floor_p1_q;
  logic [7:0] loop_src_a_q;
  logic [7:0] loop_en_q;
  logic [7:0] loop_src_b_q;
  logic [7:0] loop_ctl_c_q;

  wire wr_link_err = wr_hit(reg_req_i, leq_pkg::ADDR_LINK_ERR);
  wire wr_back_chan = wr_hit(reg_req_i, leq_pkg::ADDR_BACK_CHAN);
  wire wr_eq_manual = wr_hit(reg_req_i, leq_pkg::ADDR_EQ_MANUAL);
  wire wr_eq_floor = wr_hit(reg_req_i, leq_pkg::ADDR_EQ_FLOOR);
  wire wr_loop_a = wr_hit(reg_req_i, leq_pkg::ADDR_LOOP_SRC_A);
  wire wr_loop_en = wr_hit(reg_req_i, leq_pkg::ADDR_LOOP_EN);
  wire wr_loop_b = wr_hit(reg_req_i, leq_pkg::ADDR_LOOP_SRC_B);
  wire wr_loop_c = wr_hit(reg_req_i, leq_pkg::ADDR_LOOP_CTL_C);
  // Only the floor register is per port here; all others are shared
  wire wr_floor_p0 = wr_eq_floor && !second_port_access_i;
  wire wr_floor_p1 = wr_eq_floor && second_port_access_i;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link_err_q <= leq_pkg::RST_LINK_ERR;
      back_chan_q <= leq_pkg::RST_BACK_CHAN;
      eq_manual_q <= leq_pkg::RST_EQ_MANUAL;
    end
    else
    begin
      if (wr_link_err)
        link_err_q <= reg_req_i.wdata;
      if (wr_back_chan)
        back_chan_q <= reg_req_i.wdata;
      if (wr_eq_manual)
        eq_manual_q <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      eq_floor_p0_q <= leq_pkg::RST_EQ_FLOOR;
      eq_floor_p1_q <= leq_pkg::RST_EQ_FLOOR;
    end
    else
    begin
      if (wr_floor_p0)
        eq_floor_p0_q <= reg_req_i.wdata;
      if (wr_floor_p1)
        eq_floor_p1_q <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      loop_src_a_q <= leq_pkg::RST_LOOP;
      loop_en_q <= leq_pkg::RST_LOOP;
      loop_src_b_q <= leq_pkg::RST_LOOP;
      loop_ctl_c_q <= leq_pkg::RST_LOOP;
    end
    else
    begin
      if (wr_loop_a)
        loop_src_a_q <= reg_req_i.wdata;
      if (wr_loop_en)
        loop_en_q <= reg_req_i.wdata;
      if (wr_loop_b)
        loop_src_b_q <= reg_req_i.wdata;
      if (wr_loop_c)
        loop_ctl_c_q <= reg_req_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Port-specific reads follow the second-port selection; unmapped reads return zero
  wire [5:0] eq_state_sel = second_port_access_i ? eq_state_p1_i : eq_state_p0_i;
  wire [7:0] floor_sel = second_port_access_i ? eq_floor_p1_q : eq_floor_p0_q;
  wire [7:0] rd_mux =
    (reg_req_i.addr == leq_pkg::ADDR_EQ_STATE) ? {2'h0, eq_state_sel} :
    (reg_req_i.addr == leq_pkg::ADDR_LINK_ERR) ? link_err_q :
    (reg_req_i.addr == leq_pkg::ADDR_BACK_CHAN) ? back_chan_q :
    (reg_req_i.addr == leq_pkg::ADDR_EQ_MANUAL) ? eq_manual_q :
    (reg_req_i.addr == leq_pkg::ADDR_EQ_FLOOR) ? floor_sel :
    (reg_req_i.addr == leq_pkg::ADDR_LOOP_SRC_A) ? loop_src_a_q :
    (reg_req_i.addr == leq_pkg::ADDR_LOOP_EN) ? loop_en_q :
    (reg_req_i.addr == leq_pkg::ADDR_LOOP_SRC_B) ? loop_src_b_q :
    (reg_req_i.addr == leq_pkg::ADDR_LOOP_CTL_C) ? loop_ctl_c_q : 8'h00;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd)
        reg_rdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Link error counter
  // ----------------------------------------------------------------
  logic [3:0] err_count;

  leq_err_cnt u_err_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pix_en_i(pix_en_i),
    .link_err_i(link_err_i),
    .count_en_i(link_err_q[leq_pkg::ERR_EN_BIT]),
    .threshold_i(link_err_q[leq_pkg::ERR_THR_LSB +: 4]),
    .relock_i(relock_i),
    .lock_o(lock_o),
    .count_o(err_count)
  );

  // ----------------------------------------------------------------
  // Equalizer selection, one instance per input port
  // ----------------------------------------------------------------
  wire eq_bypass = eq_manual_q[leq_pkg::EQ_BYPASS_BIT];
  wire [5:0] eq_manual = {eq_manual_q[leq_pkg::EQ_HIGH_LSB +: 3],
                          eq_manual_q[leq_pkg::EQ_LOW_LSB +: 3]};

  leq_eq_sel u_eq_p0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(eq_bypass),
    .manual_i(eq_manual),
    .adaptive_i(eq_state_p0_i),
    .floor_i(eq_floor_p0_q[leq_pkg::EQ_FLOOR_LSB +: 4]),
    .floor_apply_i(floor_apply_i),
    .eq_sel_o(eq_sel_p0_o),
    .start_o(eq_start_p0_o)
  );

  leq_eq_sel u_eq_p1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(eq_bypass),
    .manual_i(eq_manual),
    .adaptive_i(eq_state_p1_i),
    .floor_i(eq_floor_p1_q[leq_pkg::EQ_FLOOR_LSB +: 4]),
    .floor_apply_i(floor_apply_i),
    .eq_sel_o(eq_sel_p1_o),
    .start_o(eq_start_p1_o)
  );

  // ----------------------------------------------------------------
  // Back channel and SPI pin control
  // ----------------------------------------------------------------
  wire leq_pkg::leq_bc_cfg_t bc_cfg_d =
    bc_decode(back_chan_q[leq_pkg::BC_MODE_LSB +: 3]);
  wire spi_pol = back_chan_q[leq_pkg::BC_POL_BIT];
  wire miso_gate = back_chan_q[leq_pkg::BC_MISO_BIT];
  // Data-out is only an output in reverse tunnelling; otherwise it stays released
  wire miso_oe_d = bc_cfg_d.spi && bc_cfg_d.reverse && (!miso_gate || !spi_ss_n_i);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bc_cfg_o <= '0;
      spi_launch_rise_o <= 1'b0;
      spi_sample_rise_o <= 1'b1;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end
    else
    begin
      bc_cfg_o <= bc_cfg_d;
      spi_launch_rise_o <= spi_pol;
      spi_sample_rise_o <= !spi_pol;
      spi_miso_o <= spi_miso_data_i;
      spi_miso_oe_o <= miso_oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Loop-through output
  // ----------------------------------------------------------------
  wire loop_second = loop_src_a_q[leq_pkg::LOOP_SRC_BIT];
  wire [1:0] loop_field = loop_src_b_q[leq_pkg::LOOP_FIELD_LSB +: 2];
  // A field that disagrees with the source bit mutes the data rather than guess
  wire loop_agree = loop_second ? (loop_field == leq_pkg::LOOP_FIELD_SECOND)
                                : (loop_field == leq_pkg::LOOP_FIELD_FIRST);
  wire loop_data_d = loop_agree &&
    (loop_second ? second_link_data_i : first_link_data_i);
  wire loop_on_d = loop_en_q[leq_pkg::LOOP_EN_BIT];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      loop_through_output_o <= 1'b0;
      loop_driver_on_o <= 1'b0;
    end
    else
    begin
      loop_through_output_o <= loop_data_d && loop_on_d;
      loop_driver_on_o <= loop_on_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_pin_fast_modes: assert property (
    wr_back_chan && (reg_req_i.wdata[2:0] == 3'h3) |=> ##1 (bc_cfg_o.fast && !bc_cfg_o.spi
      && bc_cfg_o.pins == 3'h4))
    else $error("four-pin fast mode not decoded");
  chk_spi_rev_fast: assert property (
    wr_back_chan && (reg_req_i.wdata[2:0] == 3'h7) |=> ##1 (bc_cfg_o.spi && bc_cfg_o.fast
      && bc_cfg_o.reverse))
    else $error("fast reverse SPI mode not decoded");
  chk_spi_edges: assert property (
    spi_launch_rise_o == $past(spi_pol) && spi_sample_rise_o != spi_launch_rise_o)
    else $error("SPI launch or sample edge does not follow polarity");
  chk_miso_tristate: assert property (
    (bc_cfg_d.reverse && miso_gate && spi_ss_n_i) |=> !spi_miso_oe_o)
    else $error("data-out driven while deselected");
  chk_manual_eq_map: assert property (
    wr_eq_manual && reg_req_i.wdata[0] |=> ##1 (eq_sel_p0_o ==
      {$past(reg_req_i.wdata[7:5], 2), $past(reg_req_i.wdata[3:1], 2)}))
    else $error("manual equalizer bits mapped wrongly");
  chk_floor_port1: assert property (
    wr_floor_p1 |=> (eq_floor_p1_q == $past(reg_req_i.wdata)) && $stable(eq_floor_p0_q))
    else $error("floor write did not reach the second port");
  chk_floor_start: assert property (
    floor_apply_i && $stable(eq_floor_p0_q) |=> eq_start_p0_o == $past(eq_floor_p0_q[3:0]))
    else $error("equalizer start floor wrong");
  chk_loop_driver: assert property (
    !loop_en_q[leq_pkg::LOOP_EN_BIT] |=> !loop_driver_on_o && !loop_through_output_o)
    else $error("loop-through active while disabled");
  chk_loop_source: assert property (
    loop_on_d && loop_second && loop_field == 2'h2 |=>
      loop_through_output_o == $past(second_link_data_i))
    else $error("loop-through does not follow the second input");
  chk_status_port: assert property (
    reg_req_i.rd && reg_req_i.addr == leq_pkg::ADDR_EQ_STATE && second_port_access_i |=>
      reg_rvalid_o && reg_rdata_o == {2'h0, $past(eq_state_p1_i)})
    else $error("status read ignored second-port access");

  cov_rev_spi_released: cover property (bc_cfg_o.reverse && !spi_miso_oe_o);
  cov_loop_second: cover property (loop_driver_on_o && loop_second && loop_agree);
  cov_floor_p1_write: cover property (wr_floor_p1);
  cov_count_saturated: cover property (err_count == 4'hf);

endmodule

/* leq_pkg.sv */
package leq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EQ_STATE = 8'h3b;
  localparam logic [7:0] ADDR_LINK_ERR = 8'h41;
  localparam logic [7:0] ADDR_BACK_CHAN = 8'h43;
  localparam logic [7:0] ADDR_EQ_MANUAL = 8'h44;
  localparam logic [7:0] ADDR_EQ_FLOOR = 8'h45;
  localparam logic [7:0] ADDR_LOOP_SRC_A = 8'h52;
  localparam logic [7:0] ADDR_LOOP_EN = 8'h56;
  localparam logic [7:0] ADDR_LOOP_SRC_B = 8'h57;
  localparam logic [7:0] ADDR_LOOP_CTL_C = 8'h63;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LINK_ERR = 8'h03;
  localparam logic [7:0] RST_BACK_CHAN = 8'h00;
  localparam logic [7:0] RST_EQ_MANUAL = 8'h60;
  localparam logic [7:0] RST_EQ_FLOOR = 8'h88;
  localparam logic [7:0] RST_LOOP = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int ERR_EN_BIT = 4;
  localparam int ERR_THR_LSB = 0;
  localparam int BC_MODE_LSB = 0;
  localparam int BC_POL_BIT = 3;
  localparam int BC_MISO_BIT = 4;
  localparam int EQ_BYPASS_BIT = 0;
  localparam int EQ_LOW_LSB = 1;
  localparam int EQ_HIGH_LSB = 5;
  localparam int EQ_FLOOR_LSB = 0;
  localparam int LOOP_SRC_BIT = 7;
  localparam int LOOP_EN_BIT = 3;
  localparam int LOOP_FIELD_LSB = 1;
  localparam logic [1:0] LOOP_FIELD_FIRST = 2'h1;
  localparam logic [1:0] LOOP_FIELD_SECOND = 2'h2;

  typedef enum logic [2:0] {
    BC_PIN_NORMAL = 3'h0,
    BC_PIN_FAST1 = 3'h1,
    BC_PIN_FAST2 = 3'h2,
    BC_PIN_FAST4 = 3'h3,
    BC_SPI_FWD_NORMAL = 3'h4,
    BC_SPI_REV_NORMAL = 3'h5,
    BC_SPI_FWD_FAST = 3'h6,
    BC_SPI_REV_FAST = 3'h7
  } leq_bc_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } leq_reg_req_t;

  typedef struct packed {
    logic fast;
    logic spi;
    logic reverse;
    logic [2:0] pins;
  } leq_bc_cfg_t;

endpackage

/* leq_err_cnt.sv */
`timescale 1ns/1ps
module leq_err_cnt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pix_en_i,
  input wire logic [2:0] link_err_i,
  input wire logic count_en_i,
  input wire logic [3:0] threshold_i,
  input wire logic relock_i,
  output logic lock_o,
  output logic [3:0] count_o
);

  logic [3:0] cnt_q;
  logic lock_q;
  wire any_err = |link_err_i;
  wire [3:0] cnt_inc = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
  // A zero threshold behaves like the disabled case: the first error drops lock
  wire thr_hit = count_en_i ? (cnt_inc >= threshold_i) : 1'b1;
  wire err_evt = pix_en_i && any_err && lock_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 4'h0;
      lock_q <= 1'b0;
    end
    else if (relock_i)
    begin
      cnt_q <= 4'h0;
      lock_q <= 1'b1;
    end
    else if (err_evt)
    begin
      cnt_q <= count_en_i ? cnt_inc : cnt_q;
      lock_q <= !thr_hit;
    end
  end

  assign lock_o = lock_q;
  assign count_o = cnt_q;

  chk_first_error_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (err_evt && !count_en_i && !relock_i) |=> !lock_q)
    else $error("lock kept after an error with counting disabled");
  chk_count_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (!count_en_i && !relock_i) |=> (cnt_q == $past(cnt_q)))
    else $error("error count moved while counting disabled");
  chk_threshold_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (err_evt && count_en_i && !relock_i) |=> (lock_q == ($past(cnt_inc) < $past(threshold_i))))
    else $error("lock drop does not match threshold");
  cov_lock_lost: cover property (@(posedge clk_i) disable iff (rst_i)
    count_en_i && lock_q ##1 !lock_q);

endmodule

/* leq_eq_sel.sv */
`timescale 1ns/1ps
module leq_eq_sel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bypass_i,
  input wire logic [5:0] manual_i,
  input wire logic [5:0] adaptive_i,
  input wire logic [3:0] floor_i,
  input wire logic floor_apply_i,
  output logic [5:0] eq_sel_o,
  output logic [3:0] start_o
);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      eq_sel_o <= 6'h00;
      start_o <= 4'h0;
    end
    else
    begin
      eq_sel_o <= bypass_i ? manual_i : adaptive_i;
      start_o <= floor_apply_i ? floor_i : 4'h0;
    end
  end

  chk_bypass_select: assert property (@(posedge clk_i) disable iff (rst_i)
    bypass_i |=> (eq_sel_o == $past(manual_i)))
    else $error("manual equalizer setting not applied in bypass");
  chk_floor_start: assert property (@(posedge clk_i) disable iff (rst_i)
    !floor_apply_i |=> (start_o == 4'h0))
    else $error("floor used without floor apply");

endmodule

/* leq_link_model.sv */
`timescale 1ns/1ps
module leq_link_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] burst_i,
  input wire logic go_i,
  output logic busy_o,
  output logic pix_en_o,
  output logic [2:0] link_err_o,
  output logic first_data_o,
  output logic second_data_o
);
  // ----------------------------------------------------------------
  // Pixel rhythm, error bursts, recovered data
  // ----------------------------------------------------------------
  logic [3:0] left_q;
  logic [1:0] chan_q;
  assign busy_o = left_q != 4'h0;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pix_en_o <= 1'b0;
      link_err_o <= 3'h0;
      left_q <= 4'h0;
      chan_q <= 2'h0;
    end
    else
    begin
      pix_en_o <= ~pix_en_o;
      link_err_o <= 3'h0;
      if (go_i && !busy_o)
        left_q <= burst_i;
      else if (!pix_en_o && busy_o)
      begin
        // Rotate so every channel gets blamed over time
        link_err_o <= 3'h1 << chan_q;
        left_q <= left_q - 4'h1;
        chan_q <= (chan_q == 2'h2) ? 2'h0 : chan_q + 2'h1;
      end
    end
  end
  // Data toggles freely so a stuck loop-through shows up
  always_ff @(posedge clk_i)
  begin
    first_data_o <= 1'($urandom);
    second_data_o <= 1'($urandom);
  end
endmodule

/* tb_leq_regs.sv */
`timescale 1ns/1ps
module tb_leq_regs;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  leq_pkg::leq_reg_req_t req = '0;
  logic spa = 1'b0, fap = 1'b0, relock = 1'b0, ss_n = 1'b1, miso_d = 1'b0, go = 1'b0;
  logic [5:0] st0 = 6'h00, st1 = 6'h00, sel0, sel1;
  logic [3:0] burst = 4'h0, start0, start1;
  logic [7:0] rdata;
  logic [2:0] lerr;
  logic rvalid, lock, miso, oe, launch, sample, lt_out, lt_on, busy, pix, da, db, pa, pb;
  leq_pkg::leq_bc_cfg_t bc;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] adr [8] = '{8'h41, 8'h43, 8'h44, 8'h45, 8'h52, 8'h56, 8'h57, 8'h63};
  logic [7:0] rst_v [8] = '{8'h03, 8'h00, 8'h60, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00};

  initial forever #2.5 clk_i = ~clk_i;

  leq_link_model link (.clk_i(clk_i), .rst_i(rst_i), .burst_i(burst), .go_i(go),
    .busy_o(busy), .pix_en_o(pix), .link_err_o(lerr), .first_data_o(da),
    .second_data_o(db));

  leq_regs dut (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .second_port_access_i(spa), .floor_apply_i(fap),
    .pix_en_i(pix), .link_err_i(lerr), .relock_i(relock), .lock_o(lock),
    .eq_state_p0_i(st0), .eq_state_p1_i(st1), .eq_sel_p0_o(sel0), .eq_sel_p1_o(sel1),
    .eq_start_p0_o(start0), .eq_start_p1_o(start1), .bc_cfg_o(bc),
    .spi_launch_rise_o(launch), .spi_sample_rise_o(sample), .spi_ss_n_i(ss_n),
    .spi_miso_data_i(miso_d), .spi_miso_o(miso), .spi_miso_oe_o(oe),
    .first_link_data_i(da), .second_link_data_i(db),
    .loop_through_output_o(lt_out), .loop_driver_on_o(lt_on));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    pa <= da;
    pb <= db;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req <= '0;
    @(negedge clk_i);
    chk({7'h0, rvalid}, 8'h01);
    d = rdata;
  endtask

  task automatic relock_link();
    @(posedge clk_i);
    relock <= 1'b1;
    @(posedge clk_i);
    relock <= 1'b0;
    @(negedge clk_i);
    chk(8'(lock), 8'h01);
  endtask

  task automatic burst_err(input logic [3:0] n);
    @(posedge clk_i);
    burst <= n;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    for (int j = 0; j < 64 && busy === 1'b1; j++)
      @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Pin modes count pins, SPI modes carry direction and rate
  function automatic logic [5:0] bc_exp(input logic [2:0] m);
    logic [2:0] p;
    p = (m == 3'h1) ? 3'h1 : (m == 3'h2) ? 3'h2 : (m == 3'h3) ? 3'h4 : 3'h0;
    return {m[2] ? m[1] : (m != 3'h0), m[2], m[2] & m[0], p};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic [7:0] v;
    logic [7:0] r;
    logic [3:0] t;
    int e;
    d = 8'($urandom(92));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    st0 <= 6'($urandom);
    st1 <= 6'($urandom);
    for (int i = 0; i < 8; i++)
    begin
      rd(adr[i], v);
      chk(v, rst_v[i]);
    end
    rd(8'h3b, v);
    chk(v, {2'h0, st0});
    @(posedge clk_i);
    spa <= 1'b1;
    rd(8'h45, v);
    chk(v, 8'h88);
    rd(8'h3b, v);
    chk(v, {2'h0, st1});
    @(posedge clk_i);
    spa <= 1'b0;
    wr(8'h40, 8'hff);
    rd(8'h40, v);
    chk(v, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      e = $urandom_range(7);
      d = 8'($urandom);
      wr(adr[e], d);
      rd(adr[e], v);
      chk(v, d);
    end
    d = 8'($urandom);
    wr(8'h45, d);
    @(posedge clk_i);
    spa <= 1'b1;
    v = ~d;
    wr(8'h45, v);
    spa <= 1'b0;
    fap <= 1'b1;
    rd(8'h45, r);
    chk(r, d);
    repeat (2) @(negedge clk_i);
    chk({start1, start0}, {v[3:0], d[3:0]});
    @(posedge clk_i);
    fap <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk({start1, start0}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      d = 8'($urandom);
      d[0] = i[0];
      wr(8'h44, d);
      repeat (3) @(negedge clk_i);
      v = i[0] ? {2'h0, d[7:5], d[3:1]} : {2'h0, st0};
      chk({2'h0, sel0}, v);
      v = i[0] ? {2'h0, d[7:5], d[3:1]} : {2'h0, st1};
      chk({2'h0, sel1}, v);
    end
    for (int i = 0; i < 32; i++)
    begin
      d = {3'h0, i[0], 1'($urandom), i[4:2]};
      wr(8'h43, d);
      ss_n <= i[1];
      miso_d <= 1'($urandom);
      repeat (3) @(negedge clk_i);
      chk({2'h0, bc}, {2'h0, bc_exp(d[2:0])});
      chk({6'h0, launch, sample}, {6'h0, d[3], ~d[3]});
      chk({6'h0, oe, miso}, {6'h0, d[2] & d[0] & (~d[4] | ~ss_n), miso_d});
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h52, {i[0], 7'h0});
      wr(8'h57, {5'h0, i[2:1], 1'b0});
      wr(8'h56, {4'h0, i[3], 3'h0}); // Half the cases leave it off
      repeat (2) @(posedge clk_i);
      repeat (4)
      begin
        @(negedge clk_i);
        v[0] = i[0] ? (i[2:1] == 2'h2 && pb) : (i[2:1] == 2'h1 && pa);
        chk({6'h0, lt_on, lt_out}, {6'h0, i[3], i[3] & v[0]});
      end
    end
    wr(8'h41, 8'h03);
    relock_link();
    burst_err(4'h1);
    chk(8'(lock), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      t = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : (i == 2) ? 4'hf : 4'($urandom_range(14, 2));
      wr(8'h41, {4'h1, t});
      relock_link();
      if (t > 4'h1)
      begin
        burst_err(t - 4'h1);
        chk(8'(lock), 8'h01);
      end
      burst_err(4'h1);
      chk(8'(lock), 8'h00);
    end
    finish_test();
  end
endmodule
